// *** shared/level_detect_regs.vh ***
// register offsets, reset values and timing constants of the level detector
// assumes a 32-bit APB slave, one aligned word per register
`ifndef LEVEL_DETECT_REGS_VH
`define LEVEL_DETECT_REGS_VH

// configuration words, index i sits at byte address 4*i
`define CFG_WORDS         10
`define OFS_FREQ_LVL_A    8'h00
`define OFS_FREQ_LVL_B    8'h04
`define OFS_FREQ_LVL_C    8'h08
`define OFS_FREQ_HYST     8'h0C
`define OFS_CUR_LVL_A     8'h10
`define OFS_CUR_TMR_A     8'h14
`define OFS_CUR_LVL_B     8'h18
`define OFS_CUR_TMR_B     8'h1C
`define OFS_CUR_LVL_C     8'h20
`define OFS_CUR_TMR_C     8'h24
`define OFS_TERM_SEL      8'h28
`define OFS_LIVE_STATUS   8'h2C
`define OFS_IRQ_STATUS    8'h30
`define OFS_IRQ_MASK      8'h34

// reset values: frequency in 0.1 Hz, current in 0.01 %, timers in 0.01 s
`define RST_FREQ_LVL      16'h01F4
`define RST_FREQ_HYST     16'h000A
`define RST_CUR_LVL       16'h2710
`define RST_CUR_TMR       16'h03E8
`define RST_TERM_SEL      32'h29252402

// terminal assignment codes
`define CODE_FDT_A        8'h02
`define CODE_FDT_B        8'h1F
`define CODE_FDT_C        8'h3A
`define CODE_OL_WARN      8'h07
`define CODE_OC_A         8'h25
`define CODE_OC_B         8'h26
`define CODE_OC_C         8'h27
`define CODE_UNDER        8'h29

// live status bit positions
`define BIT_FDT_A         0
`define BIT_FDT_B         1
`define BIT_FDT_C         2
`define BIT_OL_WARN       3
`define BIT_OC_A          4
`define BIT_OC_B          5
`define BIT_OC_C          6
`define BIT_UNDER         7

// low-current release margin: 5 % of rated in 0.01 % steps
`define UNDER_MARGIN      16'h01F4

// timing
`define CLK_MHZ           200
`define TIMER_UNIT_US     10000
`define MIN_ON_MS         100
`define TICK_CYCLES       (`TIMER_UNIT_US * `CLK_MHZ)
`define MIN_ON_CYCLES     (`MIN_ON_MS * 1000 * `CLK_MHZ)

`endif

// *** hw/level_timer.v ***
// one timed detector with a minimum on-time
// assumes the caller forms the on and off conditions and a 10 ms tick
`timescale 1ns/1ps
module level_timer #(
  parameter MIN_ON_CYCLES = 20000000,
  parameter HOLD_W        = 25
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        tick,
  input  wire        enable,
  input  wire        onCond,
  input  wire        offCond,
  input  wire [15:0] timerTicks,
  output wire        active
);

  reg              active_ff;
  reg [15:0]       cnt_ff;
  reg [HOLD_W-1:0] hold_ff;

  assign active = active_ff;

  //////////////////////////////////////////////////////////////////////////
  // the first tick after the condition arrives is partial, so firing on the
  // tick after timerTicks have been counted never switches on early
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_ff <= 1'b0;
      cnt_ff    <= 16'h0000;
      hold_ff   <= {HOLD_W{1'b0}};
    end else if (!enable) begin
      active_ff <= 1'b0;
      cnt_ff    <= 16'h0000;
      hold_ff   <= {HOLD_W{1'b0}};
    end else if (!active_ff) begin
      if (!onCond) begin
        cnt_ff <= 16'h0000;
      end else if (tick) begin
        if (cnt_ff >= timerTicks) begin
          active_ff <= 1'b1;
          cnt_ff    <= 16'h0000;
          hold_ff   <= MIN_ON_CYCLES[HOLD_W-1:0];
        end else begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end
    end else begin
      if (hold_ff != {HOLD_W{1'b0}}) begin
        hold_ff <= hold_ff - {{(HOLD_W-1){1'b0}}, 1'b1};
      end else if (offCond) begin
        active_ff <= 1'b0;
      end
    end
  end

endmodule

// *** hw/freq_current_level_detector.v ***
// frequency and current level detectors driving output terminals
// assumes frequency and current inputs synchronous to clk, APB register access
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "level_detect_regs.vh"
module freq_current_level_detector #(
  parameter TICK_CYCLES   = `TICK_CYCLES,
  parameter MIN_ON_CYCLES = `MIN_ON_CYCLES,
  parameter TERMINALS     = 4
) (
  input  wire                 clk,
  input  wire                 resetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output wire [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire [15:0]          outFreq,
  input  wire [15:0]          outCurrent,
  output wire [TERMINALS-1:0] outTerminal,
  output wire                 irq
);

  //////////////////////////////////////////////////////////////////////////
  // register file
  reg  [15:0]          cfg_ff [0:`CFG_WORDS-1];
  reg  [31:0]          termSel_ff;
  reg  [7:0]           irqStatus_ff;
  reg  [7:0]           irqMask_ff;
  reg  [31:0]          prdata_ff;
  reg                  pslverr_ff;
  reg  [7:0]           sig_ff;
  reg  [7:0]           sigPrev_ff;
  reg  [TERMINALS-1:0] term_ff;
  reg  [24:0]          div_ff;
  reg                  tick_ff;
  reg  [31:0]          nxt_prdata;
  reg                  nxt_err;
  wire                 setup;
  wire                 wrAccess;
  wire [7:0]           rise;
  wire [7:0]           nxt_sig;
  wire [2:0]           ocActive;
  wire                 underActive;
  integer              i;

  function [15:0] cfgReset;
    input integer idx;
    begin
      case (idx)
        0, 1, 2: cfgReset = `RST_FREQ_LVL;
        3:       cfgReset = `RST_FREQ_HYST;
        5, 7, 9: cfgReset = `RST_CUR_TMR;
        default: cfgReset = `RST_CUR_LVL;
      endcase
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'b00) && (addr <= `OFS_IRQ_MASK);
    end
  endfunction

  // zero-wait slave: read data is captured in the setup cycle
  assign setup    = psel & ~penable;
  assign wrAccess = psel & penable & pwrite & mapped(paddr);
  assign pready   = 1'b1;
  assign prdata   = prdata_ff;
  assign pslverr  = pslverr_ff & psel & penable;

  always @* begin
    nxt_prdata = 32'h00000000;
    nxt_err    = ~mapped(paddr);
    if (paddr < `OFS_TERM_SEL) begin
      nxt_prdata = {16'h0000, cfg_ff[paddr[5:2]]};
    end else begin
      case (paddr)
        `OFS_TERM_SEL:    nxt_prdata = termSel_ff;
        `OFS_LIVE_STATUS: nxt_prdata = {24'h000000, sig_ff};
        `OFS_IRQ_STATUS:  nxt_prdata = {24'h000000, irqStatus_ff};
        `OFS_IRQ_MASK:    nxt_prdata = {24'h000000, irqMask_ff};
        default:          nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff  <= (pwrite | nxt_err) ? 32'h00000000 : nxt_prdata;
      pslverr_ff <= nxt_err;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < `CFG_WORDS; i = i + 1) begin
        cfg_ff[i] <= cfgReset(i);
      end
      termSel_ff <= `RST_TERM_SEL;
      irqMask_ff <= 8'h00;
    end else if (wrAccess) begin
      if (paddr < `OFS_TERM_SEL) begin
        cfg_ff[paddr[5:2]] <= pwdata[15:0];
      end
      if (paddr == `OFS_TERM_SEL) begin
        termSel_ff <= pwdata;
      end
      if (paddr == `OFS_IRQ_MASK) begin
        irqMask_ff <= pwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // 10 ms time base for the detection timers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff  <= 25'h0000000;
      tick_ff <= 1'b0;
    end else if (div_ff == TICK_CYCLES[24:0] - 25'h0000001) begin
      div_ff  <= 25'h0000000;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 25'h0000001;
      tick_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frequency detectors, one shared hysteresis
  genvar f;
  generate
    for (f = 0; f < 3; f = f + 1) begin : freqCh
      wire [16:0] lower = {1'b0, outFreq} + {1'b0, cfg_ff[3]};
      // compare f + hyst < level so a hysteresis above the level cannot wrap
      assign nxt_sig[f] = sig_ff[f] ?
                          !(lower < {1'b0, cfg_ff[f]}) :
                          (outFreq > cfg_ff[f]);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // current detectors
  assign nxt_sig[`BIT_OL_WARN] = (cfg_ff[4] != 16'h0000) &&
                                 (outCurrent > cfg_ff[4]);

  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : ocCh
      wire [15:0] lvl     = cfg_ff[4 + 2 * c];
      wire [19:0] curX10  = {4'h0, outCurrent} * 20'h0000A;
      wire [19:0] lvlX9   = {4'h0, lvl} * 20'h00009;
      level_timer #(
        .MIN_ON_CYCLES (MIN_ON_CYCLES),
        .HOLD_W        (25)
      ) uTimer (
        .clk        (clk),
        .resetn     (resetn),
        .tick       (tick_ff),
        .enable     (lvl != 16'h0000),
        .onCond     (outCurrent > lvl),
        .offCond    (curX10 < lvlX9),
        .timerTicks (cfg_ff[5 + 2 * c]),
        .active     (ocActive[c])
      );
    end
  endgenerate

  wire [16:0] underRelease = {1'b0, cfg_ff[6]} + {1'b0, `UNDER_MARGIN};

  level_timer #(
    .MIN_ON_CYCLES (MIN_ON_CYCLES),
    .HOLD_W        (25)
  ) uUnder (
    .clk        (clk),
    .resetn     (resetn),
    .tick       (tick_ff),
    .enable     (cfg_ff[6] != 16'h0000),
    .onCond     (outCurrent < cfg_ff[6]),
    .offCond    ({1'b0, outCurrent} > underRelease),
    .timerTicks (cfg_ff[7]),
    .active     (underActive)
  );

  assign nxt_sig[`BIT_OC_C:`BIT_OC_A] = ocActive;
  assign nxt_sig[`BIT_UNDER]          = underActive;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sig_ff     <= 8'h00;
      sigPrev_ff <= 8'h00;
    end else begin
      sig_ff     <= nxt_sig;
      sigPrev_ff <= sig_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // terminal assignment by code
  function selectSignal;
    input [7:0] code;
    input [7:0] sig;
    begin
      case (code)
        `CODE_FDT_A:   selectSignal = sig[`BIT_FDT_A];
        `CODE_FDT_B:   selectSignal = sig[`BIT_FDT_B];
        `CODE_FDT_C:   selectSignal = sig[`BIT_FDT_C];
        `CODE_OL_WARN: selectSignal = sig[`BIT_OL_WARN];
        `CODE_OC_A:    selectSignal = sig[`BIT_OC_A];
        `CODE_OC_B:    selectSignal = sig[`BIT_OC_B];
        `CODE_OC_C:    selectSignal = sig[`BIT_OC_C];
        `CODE_UNDER:   selectSignal = sig[`BIT_UNDER];
        default:       selectSignal = 1'b0;
      endcase
    end
  endfunction

  genvar t;
  generate
    for (t = 0; t < TERMINALS; t = t + 1) begin : term
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          term_ff[t] <= 1'b0;
        end else begin
          term_ff[t] <= selectSignal(termSel_ff[(t % 4) * 8 +: 8], nxt_sig);
        end
      end
    end
  endgenerate

  assign outTerminal = term_ff;

  //////////////////////////////////////////////////////////////////////////
  // interrupts: each output switching on sets a sticky bit, set beats clear
  assign rise = sig_ff & ~sigPrev_ff;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus_ff <= 8'h00;
    end else if (wrAccess && paddr == `OFS_IRQ_STATUS) begin
      irqStatus_ff <= (irqStatus_ff & ~pwdata[7:0]) | rise;
    end else begin
      irqStatus_ff <= irqStatus_ff | rise;
    end
  end

  assign irq = |(irqStatus_ff & irqMask_ff);

endmodule

// *** test/terminal_reader.sv ***
// external equipment that samples the drive's output terminals
// assumes terminals are synchronous levels on clk
`timescale 1ns/1ps
module terminal_reader (
  input  logic       clk,
  input  logic       resetn,
  input  logic [3:0] terminals,
  output logic [3:0] seenTerm
);
  // one register stage, like an input filter on the far side
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) seenTerm <= 4'h0;
    else seenTerm <= terminals;
endmodule

// *** test/level_detect_checker.sv ***
// port-level assertions for the level detector
// assumes the terminal select word is only changed through apb writes
`timescale 1ns/1ps
`include "level_detect_regs.vh"
module level_detect_checker #(parameter int TERMINALS = 4) (
  input logic                 clk,
  input logic                 resetn,
  input logic                 psel,
  input logic                 penable,
  input logic                 pwrite,
  input logic [7:0]           paddr,
  input logic [31:0]          pwdata,
  input logic [31:0]          prdata,
  input logic                 pready,
  input logic                 pslverr,
  input logic [TERMINALS-1:0] outTerminal,
  input logic                 irq
);
  logic [31:0] termSel_ff;
  logic        acc;
  assign acc = psel && penable;
  // shadow of the select word, needed to know which signal a pin carries
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) termSel_ff <= `RST_TERM_SEL;
    else if (acc && pwrite && paddr == `OFS_TERM_SEL) termSel_ff <= pwdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_errPhase; pslverr |-> acc; endproperty
  a_errPhase: assert property (p_errPhase) else $error("pslverr outside access");
  property p_errMap; acc && paddr > `OFS_IRQ_MASK |-> pslverr; endproperty
  a_errMap: assert property (p_errMap) else $error("unmapped access accepted");
  property p_okMap; acc && paddr <= `OFS_IRQ_MASK && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_okMap: assert property (p_okMap) else $error("mapped access refused");
  property p_errRd; acc && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  a_errRd: assert property (p_errRd) else $error("refused read not zero");
  property p_unused; termSel_ff[15:8] == 8'h24 |-> !outTerminal[1]; endproperty
  a_unused: assert property (p_unused) else $error("unused code drives pin");
  property p_ocHold;
    $rose(outTerminal[2]) && termSel_ff[23:16] == `CODE_OC_A |=> outTerminal[2] [*8];
  endproperty
  a_ocHold: assert property (p_ocHold) else $error("over-current pulse short");
  property p_ucHold;
    $rose(outTerminal[3]) && termSel_ff[31:24] == `CODE_UNDER |=> outTerminal[3] [*8];
  endproperty
  a_ucHold: assert property (p_ucHold) else $error("low-current pulse short");
  property p_maskOff;
    acc && pwrite && paddr == `OFS_IRQ_MASK && pwdata[7:0] == 8'h00 |=> !irq;
  endproperty
  a_maskOff: assert property (p_maskOff) else $error("irq with mask cleared");
endmodule
bind freq_current_level_detector level_detect_checker #(.TERMINALS(TERMINALS)) uChk (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .outTerminal(outTerminal), .irq(irq));

// *** test/tb_top.sv ***
// self-checking bench: apb tasks plus input steps checked at the terminals
// assumes short tick and minimum on-time parameters, 200 MHz clock
`timescale 1ns/1ps
`include "level_detect_regs.vh"
module tb_top;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] outFreq, outCurrent;
  logic [3:0]  outTerminal, seenTerm;
  logic [7:0]  codes [3] = '{`CODE_FDT_A, `CODE_FDT_B, `CODE_FDT_C};
  // levels a/b/c are 50.0, 76.8 and 64.0 Hz, so each channel has its own on pattern
  logic [15:0] freqs [3] = '{16'h0258, 16'h02BC, 16'h0320};
  int          onFrom [3] = '{0, 2, 1};
  int          error_cnt, comparisons;
  freq_current_level_detector #(.TICK_CYCLES(10), .MIN_ON_CYCLES(50), .TERMINALS(4)) DUT (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .outFreq(outFreq), .outCurrent(outCurrent),
    .outTerminal(outTerminal), .irq(irq));
  terminal_reader uRead (.clk(clk), .resetn(resetn), .terminals(outTerminal),
    .seenTerm(seenTerm));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task end_sim;
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready is tied high, so this wait ends at the first access edge
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  // drive both inputs, wait n cycles, check terminal t as the far side sees it
  task step(input logic [15:0] f, input logic [15:0] c, input int n, input int t,
            input logic e);
    @(posedge clk);
    outFreq <= f; outCurrent <= c;
    repeat (n) @(posedge clk);
    #1 chk(seenTerm[t], e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, outFreq, outCurrent} = '0;
    resetn = 1'b0; error_cnt = 0; comparisons = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`OFS_FREQ_LVL_A, `RST_FREQ_LVL);
    rd(`OFS_FREQ_HYST, `RST_FREQ_HYST);
    rd(`OFS_CUR_TMR_A, `RST_CUR_TMR);
    apb(1'b0, 8'h38, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, 8'h01, 32'h0);
    chk(err, 1'b1);
    chk(rdata, 32'h0);
    step(16'h01F4, 16'h0, 4, 0, 1'b0);
    step(16'h01F5, 16'h0, 4, 0, 1'b1);
    step(16'h01EA, 16'h0, 4, 0, 1'b1);
    step(16'h01E9, 16'h0, 4, 0, 1'b0);
    apb(1'b1, `OFS_FREQ_LVL_B, 32'h300);
    apb(1'b1, `OFS_FREQ_LVL_C, 32'h280);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `OFS_TERM_SEL, {24'h292507, codes[i]});
      for (int j = 0; j < 3; j++) begin
        step(freqs[j], 16'h0, 4, 0, j >= onFrom[i]);
      end
    end
    apb(1'b1, `OFS_CUR_LVL_A, 32'h64);
    apb(1'b1, `OFS_CUR_TMR_A, 32'h2);
    step(16'h0, 16'h65, 4, 1, 1'b1);
    step(16'h0, 16'h64, 4, 1, 1'b0);
    step(16'h0, 16'hC8, 15, 2, 1'b0);
    step(16'h0, 16'hC8, 25, 2, 1'b1);
    step(16'h0, 16'h0, 10, 2, 1'b1);
    step(16'h0, 16'h0, 60, 2, 1'b0);
    rd(`OFS_IRQ_STATUS, 32'h1F);
    apb(1'b1, `OFS_IRQ_MASK, 32'h10);
    // mask lands at the access edge; look once it has settled
    #1 chk(irq, 1'b1);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h10);
    step(16'h0, 16'h0, 2, 2, 1'b0);
    chk(irq, 1'b0);
    step(16'h0, 16'hC8, 80, 2, 1'b1);
    step(16'h0, 16'h5A, 5, 2, 1'b1);
    step(16'h0, 16'h59, 5, 2, 1'b0);
    step(16'h0, 16'hC8, 15, 2, 1'b0);
    step(16'h0, 16'h0, 5, 2, 1'b0);
    step(16'h0, 16'hC8, 15, 2, 1'b0);
    apb(1'b1, `OFS_CUR_LVL_A, 32'h0);
    step(16'h0, 16'hC8, 60, 2, 1'b0);
    step(16'h0, 16'hC8, 1, 1, 1'b0);
    apb(1'b1, `OFS_CUR_LVL_B, 32'h3E8);
    apb(1'b1, `OFS_CUR_TMR_B, 32'h1);
    step(16'h0, 16'h32, 40, 3, 1'b1);
    step(16'h0, 16'h5DC, 60, 3, 1'b1);
    step(16'h0, 16'h5DD, 5, 3, 1'b0);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    step(16'h0, 16'h0, 2, 3, 1'b0);
    chk(irq, 1'b0);
    end_sim;
  end
  // run needs about 560 cycles
  initial begin
    #50000;
    error_cnt++;
    end_sim;
  end
endmodule
